// ### inc/swing_pkg.sv
package swing_pkg;
    // Time base
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int MIN_BREAK_MS = 1;
    // Encoder geometry
    localparam int ENC_PULSES_PER_REV = 500;
    localparam int EDGES_PER_PULSE = 4;
    localparam int ENC_EDGES_PER_REV = ENC_PULSES_PER_REV * EDGES_PER_PULSE;
    localparam int MOTOR_STEPS_PER_REV = 200;
    localparam int EDGES_PER_FULL_STEP = ENC_EDGES_PER_REV / MOTOR_STEPS_PER_REV;
    localparam int EDGES_PER_HALF_STEP = EDGES_PER_FULL_STEP / 2;
    localparam int POS_W = 24;
    localparam int MS_W = 16;
    localparam logic [1:0] QUAD_FWD_A = 2'h1;

    typedef enum logic [1:0] {MON_OFF, MON_END, MON_RUN, MON_RSVD} mon_mode_t;
    typedef enum {ST_IDLE, ST_WAIT, ST_CHECK} seq_t;

    typedef struct packed {
        mon_mode_t mode;
        logic [MS_W-1:0] swing_ms;
        logic [MS_W-1:0] break_ms;
        logic [7:0] tol_edges;
        logic reversal;
    } cfg_t;

    typedef struct packed {
        logic [2:0] a_sync;
        logic [2:0] b_sync;
        logic [1:0] ab_last;
        logic signed [POS_W-1:0] enc_pos;
        logic [31:0] tick_cnt;
        logic tick;
        seq_t st;
        logic [MS_W-1:0] swing_left;
        logic [MS_W-1:0] break_left;
        logic start_next;
        logic err_out;
    } state_t;
endpackage : swing_pkg

// ### hw/swing_check.sv
`timescale 1ns/1ps
module swing_check
    import swing_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Encoder pins
    input wire logic enc_a,
    input wire logic enc_b,
    // Configuration
    input wire cfg_t cfg,
    // Motion sequencer
    input wire logic record_done,
    input wire logic signed [POS_W-1:0] cmd_pos_steps2,
    output logic start_next,
    output logic busy,
    // Status
    output logic signed [POS_W-1:0] enc_pos,
    output logic pos_err
);
    state_t s_q, s_d;
    logic [1:0] ab_now;
    logic step_ev;
    logic up_ev;
    logic signed [POS_W-1:0] cmd_edges;
    logic signed [POS_W-1:0] lag;
    logic [POS_W-1:0] lag_abs;
    logic within_tol;
    logic [MS_W-1:0] break_eff;

    // Glitch-safe: a level counts only when the two later stages agree
    always_comb begin
        ab_now = s_q.ab_last;
        if (s_q.a_sync[1] == s_q.a_sync[2]) ab_now[1] = s_q.a_sync[2];
        if (s_q.b_sync[1] == s_q.b_sync[2]) ab_now[0] = s_q.b_sync[2];
    end

    // Gray transitions: direction from old A xor new B
    assign step_ev = (ab_now != s_q.ab_last);
    assign up_ev = s_q.ab_last[1] ^ ab_now[0];

    // Commanded position arrives in half steps; scale to edges
    assign cmd_edges = POS_W'(cmd_pos_steps2 * EDGES_PER_HALF_STEP);
    assign lag = cmd_edges - s_q.enc_pos;
    assign lag_abs = lag[POS_W-1] ? POS_W'(-lag) : POS_W'(lag);
    assign within_tol = lag_abs <= POS_W'(cfg.tol_edges);
    assign break_eff = (cfg.break_ms < MS_W'(MIN_BREAK_MS)) ? MS_W'(MIN_BREAK_MS)
                                                            : cfg.break_ms;

    always_comb begin
        s_d = s_q;
        s_d.a_sync = {s_q.a_sync[1:0], enc_a};
        s_d.b_sync = {s_q.b_sync[1:0], enc_b};
        s_d.ab_last = ab_now;
        s_d.start_next = 1'b0;
        // Illegal double jumps are dropped rather than guessed
        if (step_ev && (ab_now != ~s_q.ab_last)) begin
            s_d.enc_pos = up_ev ? s_q.enc_pos + POS_W'(1) : s_q.enc_pos - POS_W'(1);
        end
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= 32'(TICK_LEN - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h1;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (record_done) begin
                    s_d.swing_left = cfg.swing_ms;
                    s_d.break_left = cfg.reversal ? break_eff : '0;
                    s_d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (s_q.tick) begin
                    if (s_q.swing_left != '0) s_d.swing_left = s_q.swing_left - MS_W'(1);
                    if (s_q.break_left != '0) s_d.break_left = s_q.break_left - MS_W'(1);
                end
                if (cfg.mode == MON_OFF) begin
                    // No encoder involvement at all: only the break gates the start
                    if (s_q.break_left == '0) begin
                        s_d.start_next = 1'b1;
                        s_d.st = ST_IDLE;
                    end
                end else if (s_q.swing_left == '0) begin
                    s_d.st = ST_CHECK;
                end else if (s_q.break_left == '0 && within_tol) begin
                    // Break expired inside swing out: launch once rotor is settled enough
                    s_d.start_next = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_CHECK: begin
                if (s_q.tick && s_q.break_left != '0) s_d.break_left = s_q.break_left - MS_W'(1);
                if (cfg.mode != MON_OFF && lag > POS_W'(EDGES_PER_HALF_STEP))
                    s_d.err_out = 1'b1;
                if (s_q.break_left == '0) begin
                    s_d.start_next = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        if (cfg.mode == MON_RUN && s_q.st == ST_IDLE && lag > POS_W'(EDGES_PER_HALF_STEP))
            s_d.err_out = 1'b1;
        if (cfg.mode == MON_OFF) s_d.err_out = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign start_next = s_q.start_next;
    assign busy = (s_q.st != ST_IDLE);
    assign enc_pos = s_q.enc_pos;
    assign pos_err = s_q.err_out;

    // A tick held over two cycles would take two milliseconds off a counter
    property p_tick_period;
        @(posedge core_clk) disable iff (!rstn) s_q.tick |=> !s_q.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick too fast");

    property p_no_early_start;
        @(posedge core_clk) disable iff (!rstn)
            ($rose(busy) && cfg.reversal) |=> !start_next;
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("start in first cycle");

    property p_start_break;
        @(posedge core_clk) disable iff (!rstn)
            (busy && s_d.start_next) |-> s_q.break_left == '0;
    endproperty
    a_start_break: assert property (p_start_break) else $error("start before break");

    property p_tol_start;
        @(posedge core_clk) disable iff (!rstn)
            (s_q.st == ST_WAIT && s_d.start_next && cfg.mode != MON_OFF) |-> within_tol;
    endproperty
    a_tol_start: assert property (p_tol_start) else $error("start outside tolerance");

    property p_check_after_swing;
        @(posedge core_clk) disable iff (!rstn)
            (s_q.st == ST_WAIT && s_d.st == ST_CHECK) |-> s_q.swing_left == '0;
    endproperty
    a_check_after_swing: assert property (p_check_after_swing) else $error("early check");

    property p_off_no_err;
        @(posedge core_clk) disable iff (!rstn)
            cfg.mode == MON_OFF |=> !pos_err;
    endproperty
    a_off_no_err: assert property (p_off_no_err) else $error("error while off");

    property p_enc_step;
        @(posedge core_clk) disable iff (!rstn)
            !step_ev |=> enc_pos == $past(enc_pos);
    endproperty
    a_enc_step: assert property (p_enc_step) else $error("count without edge");

    property p_err_cause;
        @(posedge core_clk) disable iff (!rstn)
            $rose(pos_err) |-> $past(lag) > POS_W'(EDGES_PER_HALF_STEP);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error without lag");

    // Without a reversal there is no break, so an immediate launch is legal
    property p_break_min;
        @(posedge core_clk) disable iff (!rstn)
            ($rose(busy) && cfg.reversal) |-> s_q.break_left != '0;
    endproperty
    a_break_min: assert property (p_break_min) else $error("break too short");

    property p_swing_load;
        @(posedge core_clk) disable iff (!rstn)
            $rose(busy) |-> s_q.swing_left == cfg.swing_ms;
    endproperty
    a_swing_load: assert property (p_swing_load) else $error("swing not loaded");

    property p_err_set;
        @(posedge core_clk) disable iff (!rstn)
            (s_q.st == ST_CHECK && cfg.mode != MON_OFF && lag > POS_W'(EDGES_PER_HALF_STEP))
                |=> pos_err;
    endproperty
    a_err_set: assert property (p_err_set) else $error("lag not flagged");

    property p_start_idle;
        @(posedge core_clk) disable iff (!rstn)
            start_next |-> !busy;
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("busy at launch");

    property p_start_pulse;
        @(posedge core_clk) disable iff (!rstn)
            start_next |=> !start_next;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("launch held");

    property p_enc_count;
        @(posedge core_clk) disable iff (!rstn)
            (step_ev && ab_now != ~s_q.ab_last) |=> enc_pos != $past(enc_pos);
    endproperty
    a_enc_count: assert property (p_enc_count) else $error("edge not counted");

    c_quick_rev: cover property (@(posedge core_clk) s_q.st == ST_WAIT && s_d.start_next);
    c_check: cover property (@(posedge core_clk) s_q.st == ST_CHECK && s_d.start_next);
    c_err: cover property (@(posedge core_clk) $rose(pos_err));
    c_off_start: cover property (@(posedge core_clk) cfg.mode == MON_OFF && start_next);
    c_run_err: cover property (@(posedge core_clk) cfg.mode == MON_RUN && $rose(pos_err));
endmodule : swing_check

// ### sim/enc_model.sv
`timescale 1ns/1ps
module enc_model
    import swing_pkg::*;
(
    // Clock and target
    input wire logic core_clk,
    input wire logic signed [POS_W-1:0] tgt,
    // Encoder channels
    output logic enc_a,
    output logic enc_b
);
    logic signed [POS_W-1:0] pos_q = '0;
    logic [2:0] div_q = '0;
    // Edges spaced 8 cycles apart so the synchroniser never sees two at once
    always_ff @(posedge core_clk) begin
        div_q <= div_q + 3'h1;
        if (div_q == 3'h0 && pos_q != tgt) begin
            pos_q <= (pos_q < tgt) ? pos_q + 24'sh1 : pos_q - 24'sh1;
        end
    end
    // Gray order 00-01-11-10 counts up, one channel per edge
    assign enc_a = pos_q[1];
    assign enc_b = pos_q[1] ^ pos_q[0];
endmodule : enc_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb import swing_pkg::*;;
    localparam int T = 10;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic record_done = 1'b0;
    logic signed [POS_W-1:0] cmd = '0;
    logic signed [POS_W-1:0] tgt = '0;
    cfg_t cfg = '{MON_OFF, 16'h4, 16'h1, 8'h2, 1'b1};
    logic enc_a, enc_b, start_next, busy, pos_err;
    logic signed [POS_W-1:0] enc_pos;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    swing_check #(.TICK_LEN(T)) dut (.core_clk(core_clk), .rstn(rstn),
        .enc_a(enc_a), .enc_b(enc_b), .cfg(cfg), .record_done(record_done),
        .cmd_pos_steps2(cmd), .start_next(start_next), .busy(busy),
        .enc_pos(enc_pos), .pos_err(pos_err));
    enc_model enc (.core_clk(core_clk), .tgt(tgt), .enc_a(enc_a), .enc_b(enc_b));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // One record: move rotor, pulse record_done, time the launch of the next one
    task automatic run_rec(input mon_mode_t m, input int tg, input int sw, input int br,
                           input int lo, input int hi, input logic err);
        int n;
        n = 0;
        tgt <= tg;
        cfg.mode <= m;
        cfg.swing_ms <= sw[15:0];
        cfg.break_ms <= br[15:0];
        repeat (120) @(posedge core_clk);
        record_done <= 1'b1;
        @(posedge core_clk);
        record_done <= 1'b0;
        @(posedge core_clk);
        check("busy", 1, busy);
        while (start_next !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        check("delay", 1, n >= lo && n <= hi);
        repeat (3) @(posedge core_clk);
        check("busy_end", 0, busy);
        check("pos_err", err, pos_err);
    endtask : run_rec
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        cmd <= 24'sh2;
        tgt <= 24'sd20;
        repeat (250) @(posedge core_clk);
        check("enc_pos", 20, 32'(enc_pos));
        tgt <= -24'sd3;
        repeat (250) @(posedge core_clk);
        check("enc_pos", -3, 32'(enc_pos));
        run_rec(MON_OFF, 10, 4, 3, 2 * T, 4 * T + 5, 1'b0);
        run_rec(MON_END, 10, 20, 2, T, 3 * T + 5, 1'b0);
        run_rec(MON_END, 5, 4, 1, 3 * T, 5 * T + 5, 1'b0);
        run_rec(MON_END, 4, 4, 1, 3 * T, 5 * T + 5, 1'b1);
        cfg.mode <= MON_OFF;
        repeat (4) @(posedge core_clk);
        check("pos_err_off", 0, pos_err);
        cfg.reversal <= 1'b0;
        @(posedge core_clk);
        run_rec(MON_OFF, 4, 4, 1, 1, 1, 1'b0);
        cfg.mode <= MON_RUN;
        repeat (6) @(posedge core_clk);
        check("pos_err_run", 1, pos_err);
        final_report();
    end
endmodule : tb
